// ==== design/dccr_defs.vh ====
// Purpose: constants for the dual-cell charger control registers
// Assumes: 10 MHz core clock
// Notes:   offsets are register indices on the serial port
`ifndef DCCR_DEFS_VH
`define DCCR_DEFS_VH
`define DCCR_DEV_ADDR        7'h5a
`define DCCR_REG_MASTER      8'h01
`define DCCR_REG_SYS_CFG     8'h02
`define DCCR_REG_DIS_CFG     8'h03
`define DCCR_REG_CHG_CFG     8'h04
`define DCCR_REG_CHG_SYS_CFG 8'h05
`define DCCR_REG_STATUS      8'h06
`define DCCR_REG_SYS_FAULT   8'h07
`define DCCR_REG_BAT_FAULT   8'h08
`define DCCR_RST_MASTER      8'h00
`define DCCR_RST_SYS_CFG     8'h00
`define DCCR_RST_DIS_CFG     8'h88
`define DCCR_RST_CHG_CFG     8'h99
`define DCCR_RST_CHG_SYS_CFG 8'h92
`define DCCR_MC_SOFT_RESET   0
`define DCCR_MC_CLEAR_FAULTS 1
`define DCCR_MC_MASK_FAULTS  2
`define DCCR_MC_NO_BALANCE   3
`define DCCR_MC_FORCE_STBY   5
`define DCCR_CSC_LATCH_OFF   4
`define DCCR_CLK_HZ          10000000
`define DCCR_PB_MS           40
`define DCCR_IND_S           5
`define DCCR_ALARM_S         10
`define DCCR_ALARM_HALF_MS   500
`define DCCR_PRE_TIMER_S     3600
`define DCCR_MODE_HZ         2'b00
`define DCCR_MODE_CHG        2'b01
`define DCCR_MODE_DIS        2'b10
`define DCCR_CS_TRICKLE      3'd0
`define DCCR_CS_PRE          3'd1
`define DCCR_CS_FAST         3'd2
`define DCCR_CS_TOP          3'd3
`define DCCR_CS_EOC          3'd4
`endif

// ==== design/dccr_top.v ====
// Purpose: register bank, mode and charge sequencer of a dual-cell charger
// Assumes: serial clock well below ref_clk/4; analog comparators give levels
// Notes:   all serial and analog inputs pass two flip-flops first
`timescale 1ns/100ps
`include "dccr_defs.vh"

// Overview of operation
// - answer serial transfers only at seven-bit address 5a.
// - accept serial clock up to 1 MHz, never time out a transfer.
// - master control at 01 resets to 00; command, mask and disable bits.
// - indication config at 02 resets to 00, holds lock-out, scan, display bits.
// - discharge config at 03 resets to 88, current limit and lockout level.
// - bits 3:2 of 03 pick discharge cut-off, default 2.9 V.
// - charge config at 04 resets to 99, extra time, precondition, termination.
// - bits 3:2 of 04 pick cell termination voltage, default 4.20 V.
// - bits 7:6 of 05 scale fast current, reset 92 gives 100 percent.
// - register 05 holds bias, latch-off, hysteresis and thermistor bits.
// - status at 06 reports mode, charge state and USB connection.
// - system fault register 07 flags input, output, heat, foldback, flash.
// - battery fault register 08 flags eight battery faults.
// - idle high-impedance by default, switches off, button still watched.
// - valid adapter selects charge and runs charge states in sequence.
// - precondition commands 15 percent, leaves at precondition threshold.
// - fast charge holds current until termination voltage, then top-off.
// - top-off ends when current falls below termination current.
// - end-of-charge restarts when both cells drop 5 percent below.
// - balance bleed switches active in fast charge and top-off.
// - idle button held over 40 ms lights indicators 5 s, starts discharge.
// - faults blink alarm at 1 Hz for 10 seconds.
// - one hour precondition timer expiry forces latch-off.
module dccr_top #(
    parameter PB_CYC    = (`DCCR_CLK_HZ / 1000) * `DCCR_PB_MS,
    parameter IND_CYC   = `DCCR_CLK_HZ * `DCCR_IND_S,
    parameter HALF_CYC  = (`DCCR_CLK_HZ / 1000) * `DCCR_ALARM_HALF_MS,
    parameter ALARM_HALVES = 2 * `DCCR_ALARM_S,
    parameter PRE_CYC   = 64'd36000000000
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // serial port
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe_n,
    // analog comparator levels
    input  wire       adapter_valid,
    input  wire       push_button_input,
    input  wire       vbat_above_pre,
    input  wire       vbat_at_termination,
    input  wire       current_below_termination,
    input  wire       cells_below_recharge,
    input  wire       usb_connected,
    input  wire [4:0] sys_fault_in,
    input  wire [7:0] bat_fault_in,
    // power stage controls
    output reg  [1:0] op_mode,
    output reg  [2:0] charge_state,
    output reg        precondition_current,
    output reg        balance_enable,
    output reg        indicators_on,
    output reg        alarm_out,
    output reg        latched_off
);
    // ====================================================================
    // input synchronisers
    reg [1:0] s_scl, s_sda, s_av, s_pb, s_pre, s_term, s_ib, s_rc, s_usb;
    reg [4:0] s_sf0, s_sf1;
    reg [7:0] s_bf0, s_bf1;
    reg       scl_d, sda_d;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_scl <= 2'b11; s_sda <= 2'b11; s_av <= 2'b00; s_pb <= 2'b00;
            s_pre <= 2'b00; s_term <= 2'b00; s_ib <= 2'b00; s_rc <= 2'b00;
            s_usb <= 2'b00; s_sf0 <= 5'h00; s_sf1 <= 5'h00;
            s_bf0 <= 8'h00; s_bf1 <= 8'h00; scl_d <= 1'b1; sda_d <= 1'b1;
        end else begin
            s_scl <= {s_scl[0], scl_in}; s_sda <= {s_sda[0], sda_in};
            s_av <= {s_av[0], adapter_valid}; s_pb <= {s_pb[0], push_button_input};
            s_pre <= {s_pre[0], vbat_above_pre};
            s_term <= {s_term[0], vbat_at_termination};
            s_ib <= {s_ib[0], current_below_termination};
            s_rc <= {s_rc[0], cells_below_recharge};
            s_usb <= {s_usb[0], usb_connected};
            s_sf0 <= sys_fault_in; s_sf1 <= s_sf0;
            s_bf0 <= bat_fault_in; s_bf1 <= s_bf0;
            scl_d <= s_scl[1]; sda_d <= s_sda[1];
        end
    end
    wire scl = s_scl[1];
    wire sda = s_sda[1];
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire start_c = scl & scl_d & sda_d & ~sda;
    wire stop_c  = scl & scl_d & ~sda_d & sda;

    // ====================================================================
    // registers
    reg [7:0] master_control, system_indication_config, discharge_config;
    reg [7:0] charge_config, charge_system_config;
    reg [7:0] system_fault_flags, battery_fault_flags;
    reg       pre_expired;
    wire [7:0] operating_status = {op_mode, (charge_state == `DCCR_CS_FAST) ? 2'b10 :
                                   (charge_state == `DCCR_CS_PRE) ? 2'b01 :
                                   (charge_state == `DCCR_CS_TRICKLE) ? 2'b00 : 2'b11,
                                   s_usb[1], 3'b000};

    function [7:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `DCCR_REG_MASTER:      rd_mux = master_control;
                `DCCR_REG_SYS_CFG:     rd_mux = system_indication_config;
                `DCCR_REG_DIS_CFG:     rd_mux = discharge_config;
                `DCCR_REG_CHG_CFG:     rd_mux = charge_config;
                `DCCR_REG_CHG_SYS_CFG: rd_mux = charge_system_config;
                `DCCR_REG_STATUS:      rd_mux = operating_status;
                `DCCR_REG_SYS_FAULT:   rd_mux = system_fault_flags;
                `DCCR_REG_BAT_FAULT:   rd_mux = battery_fault_flags;
                default:               rd_mux = 8'h00;
            endcase
        end
    endfunction

    // ====================================================================
    // serial slave; no watchdog, a stalled clock simply holds state
    localparam SL_IDLE = 3'd0, SL_ADDR = 3'd1, SL_AACK = 3'd2, SL_WR = 3'd3;
    localparam SL_WACK = 3'd4, SL_RD = 3'd5, SL_RACK = 3'd6;
    reg [2:0] sl_st;
    reg [3:0] bitc;
    reg [7:0] shreg, ptr;
    wire [7:0] rd_byte = rd_mux(ptr);
    reg       rnw, have_ptr, wr_pulse;
    reg [7:0] wr_data;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sl_st <= SL_IDLE; bitc <= 4'h0; shreg <= 8'h00; ptr <= 8'h00;
            rnw <= 1'b0; have_ptr <= 1'b0; wr_pulse <= 1'b0; wr_data <= 8'h00;
            sda_out <= 1'b0; sda_oe_n <= 1'b1;
        end else begin
            wr_pulse <= 1'b0;
            // step the pointer only after the bank has used it
            if (wr_pulse) ptr <= ptr + 8'h01;
            if (stop_c) begin
                sl_st <= SL_IDLE; sda_oe_n <= 1'b1;
            end else if (start_c) begin
                sl_st <= SL_ADDR; bitc <= 4'h0; have_ptr <= 1'b0; sda_oe_n <= 1'b1;
            end else begin
                case (sl_st)
                    SL_IDLE: sda_oe_n <= 1'b1;
                    SL_ADDR, SL_WR: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda};
                            bitc <= bitc + 4'h1;
                        end
                        if (scl_fall && bitc == 4'h8) begin
                            bitc <= 4'h0;
                            if (sl_st == SL_ADDR) begin
                                if (shreg[7:1] == `DCCR_DEV_ADDR) begin
                                    rnw <= shreg[0]; sl_st <= SL_AACK; sda_oe_n <= 1'b0;
                                end else
                                    sl_st <= SL_IDLE;
                            end else begin
                                if (!have_ptr) begin
                                    ptr <= shreg; have_ptr <= 1'b1;
                                end else begin
                                    wr_data <= shreg; wr_pulse <= 1'b1;
                                end
                                sl_st <= SL_WACK; sda_oe_n <= 1'b0;
                            end
                        end
                    end
                    SL_AACK, SL_WACK: if (scl_fall) begin
                        if (sl_st == SL_AACK && rnw) begin
                            shreg <= rd_byte; sl_st <= SL_RD;
                            sda_oe_n <= rd_byte[7];
                        end else begin
                            sl_st <= SL_WR; sda_oe_n <= 1'b1;
                        end
                    end
                    SL_RD: if (scl_fall) begin
                        if (bitc == 4'h7) begin
                            bitc <= 4'h0; sl_st <= SL_RACK; sda_oe_n <= 1'b1;
                            ptr <= ptr + 8'h01;
                        end else begin
                            bitc <= bitc + 4'h1;
                            shreg <= {shreg[6:0], 1'b0};
                            sda_oe_n <= shreg[6];
                        end
                    end
                    SL_RACK: begin
                        if (scl_rise) rnw <= ~sda;
                        if (scl_fall) begin
                            if (rnw) begin
                                shreg <= rd_byte; sl_st <= SL_RD;
                                sda_oe_n <= rd_byte[7];
                            end else sl_st <= SL_IDLE;
                        end
                    end
                    default: sl_st <= SL_IDLE;
                endcase
            end
        end
    end

    // ====================================================================
    // register writes and fault capture
    wire soft_rst = master_control[`DCCR_MC_SOFT_RESET];
    wire clr_flt  = master_control[`DCCR_MC_CLEAR_FAULTS];
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            master_control <= `DCCR_RST_MASTER;
            system_indication_config <= `DCCR_RST_SYS_CFG;
            discharge_config <= `DCCR_RST_DIS_CFG;
            charge_config <= `DCCR_RST_CHG_CFG;
            charge_system_config <= `DCCR_RST_CHG_SYS_CFG;
            system_fault_flags <= 8'h00;
            battery_fault_flags <= 8'h00;
        end else begin
            // command bits live one cycle only
            master_control[1:0] <= 2'b00;
            if (soft_rst) begin
                master_control <= `DCCR_RST_MASTER;
                system_indication_config <= `DCCR_RST_SYS_CFG;
                discharge_config <= `DCCR_RST_DIS_CFG;
                charge_config <= `DCCR_RST_CHG_CFG;
                charge_system_config <= `DCCR_RST_CHG_SYS_CFG;
            end else if (wr_pulse) begin
                case (ptr)
                    `DCCR_REG_MASTER:      master_control <= wr_data & 8'h3f;
                    `DCCR_REG_SYS_CFG:     system_indication_config <= wr_data & 8'h17;
                    `DCCR_REG_DIS_CFG:     discharge_config <= wr_data & 8'hec;
                    `DCCR_REG_CHG_CFG:     charge_config <= wr_data;
                    `DCCR_REG_CHG_SYS_CFG: charge_system_config <= wr_data & 8'hf6;
                    default: ;
                endcase
            end
            // new fault wins over clear
            system_fault_flags <= ((clr_flt ? 8'h00 : system_fault_flags) |
                                   {s_sf1, 3'b000});
            battery_fault_flags <= ((clr_flt ? 8'h00 : battery_fault_flags) |
                                    s_bf1 | {6'h00, pre_expired, 1'b0});
        end
    end

    // ====================================================================
    // mode, charge sequencer and timers
    reg [31:0] pb_cnt, ind_cnt, half_cnt;
    reg [5:0]  halves;
    reg [63:0] pre_cnt;
    reg        any_fault_d;
    wire any_fault = (|system_fault_flags | |battery_fault_flags) &
                     ~master_control[`DCCR_MC_MASK_FAULTS];
    wire pb_long = (pb_cnt >= PB_CYC - 1);
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_mode <= `DCCR_MODE_HZ; charge_state <= `DCCR_CS_TRICKLE;
            precondition_current <= 1'b0; balance_enable <= 1'b0;
            indicators_on <= 1'b0; alarm_out <= 1'b0; latched_off <= 1'b0;
            pb_cnt <= 32'h0; ind_cnt <= 32'h0; half_cnt <= 32'h0; halves <= 6'h0;
            pre_cnt <= 64'h0; pre_expired <= 1'b0; any_fault_d <= 1'b0;
        end else begin
            pre_expired <= 1'b0;
            pb_cnt <= s_pb[1] ? ((pb_long) ? pb_cnt : pb_cnt + 32'h1) : 32'h0;
            if (master_control[`DCCR_MC_FORCE_STBY] || latched_off) begin
                op_mode <= `DCCR_MODE_HZ;
                if (clr_flt) latched_off <= 1'b0;
            end else if (s_av[1]) begin
                op_mode <= `DCCR_MODE_CHG;
                case (charge_state)
                    `DCCR_CS_TRICKLE: charge_state <= `DCCR_CS_PRE;
                    `DCCR_CS_PRE: if (s_pre[1]) charge_state <= `DCCR_CS_FAST;
                    `DCCR_CS_FAST: if (s_term[1]) charge_state <= `DCCR_CS_TOP;
                    `DCCR_CS_TOP: if (s_ib[1]) charge_state <= `DCCR_CS_EOC;
                    `DCCR_CS_EOC: if (s_rc[1]) charge_state <= `DCCR_CS_FAST;
                    default: charge_state <= `DCCR_CS_TRICKLE;
                endcase
            end else begin
                charge_state <= `DCCR_CS_TRICKLE;
                if (op_mode == `DCCR_MODE_CHG) op_mode <= `DCCR_MODE_HZ;
                if (op_mode == `DCCR_MODE_HZ && pb_cnt == PB_CYC - 1) begin
                    op_mode <= `DCCR_MODE_DIS; ind_cnt <= IND_CYC;
                end
            end
            // precondition watchdog
            if (op_mode == `DCCR_MODE_CHG && charge_state == `DCCR_CS_PRE) begin
                pre_cnt <= pre_cnt + 64'h1;
                if (pre_cnt == PRE_CYC - 1) begin
                    pre_expired <= 1'b1; latched_off <= 1'b1;
                    charge_state <= `DCCR_CS_TRICKLE;
                end
            end else pre_cnt <= 64'h0;
            precondition_current <= (op_mode == `DCCR_MODE_CHG) &&
                                    (charge_state == `DCCR_CS_PRE);
            balance_enable <= (op_mode == `DCCR_MODE_CHG) &&
                              (charge_state == `DCCR_CS_FAST ||
                               charge_state == `DCCR_CS_TOP) &&
                              ~master_control[`DCCR_MC_NO_BALANCE];
            if (ind_cnt != 32'h0) ind_cnt <= ind_cnt - 32'h1;
            indicators_on <= (ind_cnt != 32'h0);
            // alarm: restarts only when the unmasked fault summary rises from none
            any_fault_d <= any_fault;
            if (any_fault && !any_fault_d) begin
                halves <= ALARM_HALVES[5:0]; half_cnt <= 32'h0; alarm_out <= 1'b1;
            end else if (halves != 6'h0) begin
                if (half_cnt == HALF_CYC - 1) begin
                    half_cnt <= 32'h0; halves <= halves - 6'h1;
                    alarm_out <= (halves > 6'h1) ? ~alarm_out : 1'b0;
                end else half_cnt <= half_cnt + 32'h1;
            end else alarm_out <= 1'b0;
        end
    end
endmodule // dccr_top

// ==== tb/dccr_asserts.sv ====
// Purpose: port checks for the charger control block
// Assumes: shortened timer parameters handed on by the bind
// Notes:   long intervals are measured by counters, not repetitions
`timescale 1ns/100ps
module dccr_asserts #(
    parameter PB_CYC   = 20,
    parameter IND_CYC  = 200,
    parameter HALF_CYC = 10,
    parameter PRE_CYC  = 500
) (
    // clock and reset
    input wire       ref_clk,
    input wire       rst,
    // comparator levels
    input wire       adapter_valid,
    input wire       vbat_above_pre,
    input wire       vbat_at_termination,
    input wire       current_below_termination,
    input wire       cells_below_recharge,
    // power stage controls
    input wire [1:0] op_mode,
    input wire [2:0] charge_state,
    input wire       precondition_current,
    input wire       balance_enable,
    input wire       indicators_on,
    input wire       alarm_out,
    input wire       latched_off
);
    // ==========
    // interval counters
    int  hi_cnt, ind_cnt, pre_cnt;
    wire chg = op_mode == 2'b01 && !latched_off;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_cnt  <= 0;
            ind_cnt <= 0;
            pre_cnt <= 0;
        end else begin
            hi_cnt  <= alarm_out ? hi_cnt + 1 : 0;
            ind_cnt <= indicators_on ? ind_cnt + 1 : 0;
            pre_cnt <= (chg && charge_state == 3'd1) ? pre_cnt + 1 : 0;
        end
    end
    // ==========
    // properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // inputs held long enough to pass the synchronisers
    sequence s_held(cs, cond);
        (chg && charge_state == cs && cond) [*3];
    endsequence
    property p_pre_cur; s_held(3'd1, 1'b1) |-> precondition_current; endproperty
    a_pre_cur: assert property (p_pre_cur) else $error("no reduced current");
    property p_pre_exit; s_held(3'd1, vbat_above_pre) |-> ##[0:4] charge_state == 3'd2; endproperty
    a_pre_exit: assert property (p_pre_exit) else $error("stuck in precondition");
    property p_fast_exit; s_held(3'd2, vbat_at_termination) |-> ##[0:4] charge_state == 3'd3; endproperty
    a_fast_exit: assert property (p_fast_exit) else $error("stuck in fast charge");
    property p_top_exit; s_held(3'd3, current_below_termination) |-> ##[0:4] charge_state == 3'd4;
    endproperty
    a_top_exit: assert property (p_top_exit) else $error("stuck in top-off");
    property p_rechg; s_held(3'd4, cells_below_recharge) |-> ##[0:4] charge_state != 3'd4; endproperty
    a_rechg: assert property (p_rechg) else $error("no recharge");
    property p_bal; (chg && charge_state inside {3'd2, 3'd3}) [*3] |-> balance_enable; endproperty
    a_bal: assert property (p_bal) else $error("balance off while charging");
    property p_adp; (adapter_valid && !latched_off && op_mode != 2'b10) [*6] |-> ##[0:4] chg;
    endproperty
    a_adp: assert property (p_adp) else $error("adapter did not select charge");
    property p_half; $fell(alarm_out) |-> hi_cnt == HALF_CYC; endproperty
    a_half: assert property (p_half) else $error("alarm on time wrong");
    property p_ind; $fell(indicators_on) |-> ind_cnt == IND_CYC; endproperty
    a_ind: assert property (p_ind) else $error("indicator time wrong");
    property p_pre_tmr; chg && charge_state == 3'd1 |-> pre_cnt < PRE_CYC + 4; endproperty
    a_pre_tmr: assert property (p_pre_tmr) else $error("precondition timer overran");
endmodule // dccr_asserts

bind dccr_top dccr_asserts #(
    .PB_CYC(PB_CYC), .IND_CYC(IND_CYC), .HALF_CYC(HALF_CYC), .PRE_CYC(PRE_CYC)
) dccr_asserts_i (
    .ref_clk(ref_clk), .rst(rst), .adapter_valid(adapter_valid),
    .vbat_above_pre(vbat_above_pre), .vbat_at_termination(vbat_at_termination),
    .current_below_termination(current_below_termination),
    .cells_below_recharge(cells_below_recharge), .op_mode(op_mode),
    .charge_state(charge_state), .precondition_current(precondition_current),
    .balance_enable(balance_enable), .indicators_on(indicators_on),
    .alarm_out(alarm_out), .latched_off(latched_off)
);

// ==== tb/dccr_host_model.sv ====
// Purpose: serial host that configures and polls the charger block
// Assumes: open-drain data line with a pull-up resolved in the bench
// Notes:   clock stands high between frames; hold_low stretches each bit
`timescale 1ns/100ps
module dccr_host_model (
    // pacing clock
    input  wire ref_clk,
    // serial wires
    input  wire sda_line,
    output reg  scl,
    output reg  sda_low
);
    int hold_low = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // quarter of the 800 ns serial period
    task q;
        repeat (2) @(negedge ref_clk);
    endtask
    task start;
        scl = 1'b1;
        q;
        sda_low = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask
    task stop;
        sda_low = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b0;
        q;
    endtask
    // nine bits; a 1 releases the line so the device can answer
    task xfer(input [8:0] tx, output [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !tx[i];
            repeat (hold_low) q;
            q;
            scl = 1'b1;
            q;
            rx[i] = sda_line;
            q;
            scl = 1'b0;
            q;
        end
    endtask
endmodule // dccr_host_model

// ==== tb/test_dccr_top.sv ====
// Purpose: self-checking bench for the charger control block
// Assumes: host model drives the serial wires, bench drives the levels
// Notes:   timers run with shortened parameters
`timescale 1ns/100ps
module test_dccr_top;
    // ==========
    // signals
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       adp = 0, pb = 0, v_pre = 0, v_term = 0, i_low = 0, rechg = 0, usb = 0;
    logic [4:0] sfi     = 5'h00;
    logic [7:0] bfi     = 8'h00;
    logic       scl, host_low, sda_out, sda_oe_n, pre_i, bal, ind, alarm, latched;
    logic [1:0] op_mode;
    logic [2:0] charge_state;
    int         fail_count = 0;
    int         checks     = 0;
    wire        sda_line = (host_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
    always #50 ref_clk = ~ref_clk;
    dccr_host_model host_i (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
    dccr_top #(.PB_CYC(20), .IND_CYC(200), .HALF_CYC(10), .PRE_CYC(500)) dccr_top_i (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .adapter_valid(adp), .push_button_input(pb),
        .vbat_above_pre(v_pre), .vbat_at_termination(v_term), .current_below_termination(i_low),
        .cells_below_recharge(rechg), .usb_connected(usb), .sys_fault_in(sfi),
        .bat_fault_in(bfi), .op_mode(op_mode), .charge_state(charge_state),
        .precondition_current(pre_i), .balance_enable(bal), .indicators_on(ind),
        .alarm_out(alarm), .latched_off(latched));
    // ==========
    // shared tasks
    task check(input [7:0] seen, input [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task send(input [7:0] b, output ok);
        logic [8:0] r;
        host_i.xfer({b, 1'b1}, r);
        ok = !r[0];
    endtask
    task wr(input [7:0] ptr, input [7:0] d);
        logic a0, a1;
        host_i.start;
        send({7'h5a, 1'b0}, a0);
        send(ptr, a1);
        send(d, a1);
        host_i.stop;
        check(8'(a0), 8'h01);
    endtask
    task rd_chk(input [7:0] ptr, input [7:0] exp);
        logic       a0, a1;
        logic [8:0] r;
        host_i.start;
        send({7'h5a, 1'b0}, a0);
        send(ptr, a1);
        host_i.stop;
        host_i.start;
        send({7'h5a, 1'b1}, a1);
        host_i.xfer(9'h1ff, r);
        host_i.stop;
        check({6'h0, a0, a1}, 8'h03);
        check(r[8:1], exp);
    endtask
    // waits for a mode and a state (or any state but cs when neq)
    task wait_out(input [1:0] m, input [2:0] cs, input neq);
        int n;
        for (n = 0; n < 300; n++) begin
            if (op_mode === m && (neq ? charge_state !== cs : charge_state === cs)) break;
            @(negedge ref_clk);
        end
        check(8'(op_mode), 8'(m));
        if (n == 300) begin
            fail_count++;
            give_verdict;
        end
        repeat (3) @(negedge ref_clk);
    endtask
    // ==========
    // scenarios
    task t_regs;
        logic a;
        logic [7:0] dflt [8] = '{8'h00, 8'h00, 8'h88, 8'h99, 8'h92, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++) rd_chk(8'(i + 1), dflt[i]);
        host_i.start;
        send({7'h5b, 1'b0}, a);
        host_i.stop;
        check(8'(a), 8'h00);
        host_i.hold_low = 100;
        wr(8'h04, 8'h6c);
        host_i.hold_low = 0;
        rd_chk(8'h04, 8'h6c);
        wr(8'h03, 8'h40);
        rd_chk(8'h03, 8'h40);
        wr(8'h05, 8'h34);
        rd_chk(8'h05, 8'h34);
        wr(8'h06, 8'hff);
        rd_chk(8'h06, 8'h00);
        wr(8'h09, 8'h5a);
        rd_chk(8'h09, 8'h00);
        wr(8'h01, 8'h01);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h04, 8'h99);
    endtask
    task t_faults;
        int   n;
        logic last;
        n = 0;
        last = alarm;
        {sfi, bfi} = {5'h15, 8'ha5};
        repeat (260) begin
            @(negedge ref_clk);
            if (alarm !== last) n++;
            last = alarm;
        end
        check(8'(n), 8'd20);
        rd_chk(8'h07, 8'ha8);
        rd_chk(8'h08, 8'ha5);
        {sfi, bfi} = 13'h0;
        wr(8'h01, 8'h02);
        rd_chk(8'h07, 8'h00);
        rd_chk(8'h08, 8'h00);
        check(8'(latched), 8'h00);
    endtask
    task t_charge;
        adp = 1;
        wait_out(2'b01, 3'd1, 0);
        check(8'(pre_i), 8'h01);
        rd_chk(8'h06, 8'h50);
        {v_pre, usb} = 2'b11;
        wait_out(2'b01, 3'd2, 0);
        check(8'(bal), 8'h01);
        rd_chk(8'h06, 8'h68);
        v_term = 1;
        wait_out(2'b01, 3'd3, 0);
        i_low = 1;
        wait_out(2'b01, 3'd4, 0);
        check(8'(bal), 8'h00);
        {v_term, i_low, rechg} = 3'b001;
        wait_out(2'b01, 3'd4, 1);
        {adp, v_pre, rechg, usb} = 4'h0;
        wait_out(2'b00, 3'd7, 1);
        check(8'(pre_i), 8'h00);
    endtask
    task t_timer;
        int n;
        adp = 1;
        wait_out(2'b01, 3'd1, 0);
        for (n = 0; n < 700 && latched !== 1'b1; n++) @(negedge ref_clk);
        check(8'(latched), 8'h01);
        if (n == 700) give_verdict;
        adp = 0;
        rd_chk(8'h08, 8'h02);
        wr(8'h01, 8'h02);
        check(8'(latched), 8'h00);
    endtask
    task t_button;
        pb = 1;
        repeat (10) @(negedge ref_clk);
        pb = 0;
        repeat (10) @(negedge ref_clk);
        check(8'(op_mode), 8'h00);
        pb = 1;
        wait_out(2'b10, 3'd7, 1);
        pb = 0;
        check(8'(ind), 8'h01);
        repeat (250) @(negedge ref_clk);
        check(8'(ind), 8'h00);
        wr(8'h01, 8'h20);
        wait_out(2'b00, 3'd7, 1);
        wr(8'h01, 8'h00);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        t_regs;
        t_faults;
        t_charge;
        t_timer;
        t_button;
        give_verdict;
    end
endmodule // test_dccr_top
